// file: lgb_pkg.sv
// Purpose: Shared constants and types for the link pin bridge
// Assumes: 32-bit APB, one register per aligned word
// Notes: Offsets printed as word indices; bus address is four times the index
//
// Functional notes
// [RULE_01] Seven local pins, each settable to output driven by forward-channel data.
// [RULE_02] Each receive port carries at most four forward pin signals.
// [RULE_03] Any forward pin from either port routes to any local pin.
// [RULE_04] Forward update every frame for one pin, two for two, five for three/four.
// [RULE_05] Forward latency stays constant; only jitter grows with linked pins.
// [RULE_06] Source should oversample forward-linked pins at least four times.
// [RULE_07] Ports in parallel-video mode are not forward pin sources.
// [RULE_08] Frame sync or internal control signals may drive any local pin.
// [RULE_09] All pins come up as inputs after start-up.
// [RULE_10] Four back-channel slots per port, any of seven pins per slot.
// [RULE_11] One pin may feed several back-channel slots.
// [RULE_12] Slots sampled once per 30-bit back-channel frame and sent in it.
// [RULE_13] Back channel runs at 50 Mbps (20 ns) or 2.5 Mbps (400 ns) per bit.
// [RULE_14] Back-channel pin inputs should switch below a quarter of sampling rate.
// [RULE_15] Internal or external frame sync assignable to any back-channel slot.
// [RULE_16] Per-pin input and pulldown disable; both enabled after reset.
// [RULE_17] Input and pulldown registers hold one bit per pin at its index.
// [RULE_18] Select 000 drives register level; 001-011 drive OR/AND of lock and pass.
package lgb_pkg;
	localparam int NUM_PINS = 7;
	localparam int NUM_PORTS = 2;
	localparam int FWD_PER_PORT = 4;
	localparam int BC_SLOTS = 4;
	localparam int BC_FRAME_BITS = 30;
	localparam int CLK_PERIOD_NS = 100;
	localparam int BC_BIT_FAST_NS = 20;
	localparam int BC_BIT_SLOW_NS = 400;
	// Frame periods in pclk cycles, converted from ns and rounded down, not clamped
	localparam int BC_FRAME_FAST_CYC = (BC_FRAME_BITS * BC_BIT_FAST_NS) / CLK_PERIOD_NS;
	localparam int BC_FRAME_SLOW_CYC = (BC_FRAME_BITS * BC_BIT_SLOW_NS) / CLK_PERIOD_NS;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PIN_INPUT_ENABLE = 8'h0f;
	localparam logic [7:0] IDX_BC_MAP_A = 8'h6e;
	localparam logic [7:0] IDX_BC_MAP_B = 8'h6f;
	localparam logic [7:0] IDX_PIN_PULLDOWN = 8'hbe;
	localparam logic [7:0] IDX_PIN_OUT_CFG0 = 8'hc0;
	localparam logic [7:0] IDX_FWD_CFG = 8'hc8;
	localparam logic [7:0] IDX_BC_CFG = 8'hc9;
	localparam logic [7:0] IDX_PIN_STATUS = 8'hca;

	localparam logic [7:0] RST_INPUT_ENABLE = 8'h7f;
	localparam logic [7:0] RST_PULLDOWN = 8'h00;
	localparam logic [7:0] RST_PIN_OUT_CFG = 8'h00;
	localparam logic [7:0] RST_BC_MAP = 8'h00;
	localparam logic [7:0] RST_FWD_CFG = 8'h00;
	localparam logic [7:0] RST_BC_CFG = 8'h00;

	// Pin output config fields
	localparam int POC_EN_BIT = 0;
	localparam int POC_LEVEL_BIT = 1;
	localparam int POC_SEL_LSB = 2;
	localparam int POC_SRC_LSB = 5;

	// Source groups of a pin output
	localparam logic [2:0] SRC_PORT0 = 3'h0;
	localparam logic [2:0] SRC_PORT1 = 3'h1;
	localparam logic [2:0] SRC_DEVICE = 3'h4;

	// Device-status selects
	localparam logic [2:0] DEV_LEVEL = 3'h0;
	localparam logic [2:0] DEV_OR_LOCK = 3'h1;
	localparam logic [2:0] DEV_AND_LOCK = 3'h2;
	localparam logic [2:0] DEV_AND_PASS = 3'h3;
	localparam logic [2:0] DEV_FSYNC = 3'h4;
	localparam logic [2:0] DEV_IRQ_HI = 3'h5;
	localparam logic [2:0] DEV_IRQ_LO = 3'h6;

	// Back-channel slot source codes; 0..6 are pins
	localparam logic [2:0] SLOT_FSYNC_INT = 3'h7;

	typedef struct packed {
		logic [NUM_PORTS-1:0] lock;
		logic [NUM_PORTS-1:0] pass;
		logic [NUM_PORTS-1:0] port_en;
		logic [NUM_PORTS-1:0] video_mode;
	} lgb_port_status_t;

	typedef struct packed {
		logic [FWD_PER_PORT-1:0] bits;
		logic strobe;
	} lgb_fwd_frame_t;

	typedef struct packed {
		logic [BC_SLOTS-1:0] bits;
		logic strobe;
	} lgb_bc_frame_t;
endpackage

// file: lgb_fwd_rx.sv
// Purpose: Per-port forward pin value holder
// Assumes: Frame strobe is one pclk pulse per forward frame
// Notes: Cadence decides which frame refreshes the held values
`timescale 1ns/1ps
`default_nettype none
module lgb_fwd_rx #(
	parameter int NBITS = lgb_pkg::FWD_PER_PORT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire lgb_pkg::lgb_fwd_frame_t frame,
	input wire logic [NBITS-1:0] link_en,
	input wire logic video_mode,
	output logic [NBITS-1:0] values
);
	logic [NBITS-1:0] values_reg;
	logic [2:0] frame_cnt_reg;
	logic [2:0] period;
	logic [2:0] ones;

	always_comb begin
		ones = 3'h0;
		for (int i = 0; i < NBITS; i++) begin
			ones = ones + {2'b00, link_en[i]};
		end
		case (ones)
			3'h0, 3'h1: period = 3'h1;
			3'h2: period = 3'h2;
			default: period = 3'h5; // RULE_04
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt_reg <= 3'h0;
		end else if (frame.strobe) begin
			frame_cnt_reg <= (frame_cnt_reg + 3'h1 >= period) ? 3'h0 : frame_cnt_reg + 3'h1; // RULE_04
		end
	end

	// Values refresh on the closing frame of a group, so latency does not grow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			values_reg <= '0;
		end else if (frame.strobe && !video_mode && (frame_cnt_reg + 3'h1 >= period)) begin // RULE_07 RULE_05
			values_reg <= frame.bits & link_en; // RULE_02
		end
	end

	assign values = values_reg;
endmodule
`default_nettype wire

// file: lgb_bc_tx.sv
// Purpose: Back-channel slot sampler for one port
// Assumes: Pins already synchronised to pclk
// Notes: Samples once per 30-bit frame time
`timescale 1ns/1ps
`default_nettype none
module lgb_bc_tx #(
	parameter int FAST_CYC = lgb_pkg::BC_FRAME_FAST_CYC,
	parameter int SLOW_CYC = lgb_pkg::BC_FRAME_SLOW_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow_rate,
	input wire logic [lgb_pkg::BC_SLOTS-1:0] slot_src,
	output lgb_pkg::lgb_bc_frame_t frame
);
	logic [11:0] cnt_reg;
	logic [11:0] limit;
	lgb_pkg::lgb_bc_frame_t frame_reg;

	assign limit = slow_rate ? 12'(SLOW_CYC - 1) : 12'(FAST_CYC - 1); // RULE_13

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 12'h000;
		end else begin
			cnt_reg <= (cnt_reg >= limit) ? 12'h000 : cnt_reg + 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_reg <= '0;
		end else begin
			frame_reg.strobe <= (cnt_reg >= limit); // RULE_12
			if (cnt_reg >= limit) begin
				frame_reg.bits <= slot_src; // RULE_12
			end
		end
	end

	assign frame = frame_reg;
endmodule
`default_nettype wire

// file: lgb_top.sv
// Purpose: Link pin bridge with APB register file
// Assumes: Single pclk domain, pins synchronised in two stages
// Notes: Pad-level pulldown and input gating are outputs to the pad ring
`timescale 1ns/1ps
`default_nettype none
module lgb_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [lgb_pkg::NUM_PINS-1:0] pin_in,
	output logic [lgb_pkg::NUM_PINS-1:0] pin_out,
	output logic [lgb_pkg::NUM_PINS-1:0] pin_oe,
	output logic [lgb_pkg::NUM_PINS-1:0] pin_ie,
	output logic [lgb_pkg::NUM_PINS-1:0] pin_pd_en,
	input wire lgb_pkg::lgb_fwd_frame_t fwd_frame0,
	input wire lgb_pkg::lgb_fwd_frame_t fwd_frame1,
	input wire lgb_pkg::lgb_port_status_t port_status,
	input wire logic frame_sync_signal,
	input wire logic ext_frame_sync,
	input wire logic dev_irq,
	output lgb_pkg::lgb_bc_frame_t bc_frame0,
	output lgb_pkg::lgb_bc_frame_t bc_frame1
);
	localparam int NP = lgb_pkg::NUM_PINS;

	logic [7:0] input_enable_reg;
	logic [7:0] pulldown_reg;
	logic [7:0] bc_map_a_reg;
	logic [7:0] bc_map_b_reg;
	logic [7:0] fwd_cfg_reg;
	logic [7:0] bc_cfg_reg;
	logic [7:0] out_cfg_reg [NP];
	logic [NP-1:0] pin_meta_reg;
	logic [NP-1:0] pin_sync_reg;
	logic [1:0] efs_sync_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [NP-1:0] pin_out_reg;
	logic [NP-1:0] pin_oe_reg;
	logic [lgb_pkg::FWD_PER_PORT-1:0] fwd_val0;
	logic [lgb_pkg::FWD_PER_PORT-1:0] fwd_val1;
	logic [lgb_pkg::BC_SLOTS-1:0] slot_src0;
	logic [lgb_pkg::BC_SLOTS-1:0] slot_src1;
	logic [7:0] idx;
	logic wr_en;
	logic rd_en;
	logic hit;

	// Slot code: 0..6 pin, 7 frame sync. Map byte packs two 4-bit slot selects,
	// bit 3 of each nibble selects the external frame-sync input.
	function automatic logic slot_pick(input logic [3:0] code, input logic [NP-1:0] pins,
		input logic fs_int, input logic fs_ext);
		if (code[2:0] == lgb_pkg::SLOT_FSYNC_INT) begin
			slot_pick = code[3] ? fs_ext : fs_int; // RULE_15
		end else begin
			slot_pick = pins[code[2:0]]; // RULE_10 RULE_11
		end
	endfunction

	function automatic logic and_en(input logic [lgb_pkg::NUM_PORTS-1:0] v,
		input logic [lgb_pkg::NUM_PORTS-1:0] en);
		and_en = (en != '0) && ((v & en) == en);
	endfunction

	assign idx = paddr[9:2];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign hit = (idx == lgb_pkg::IDX_PIN_INPUT_ENABLE) || (idx == lgb_pkg::IDX_BC_MAP_A) ||
		(idx == lgb_pkg::IDX_BC_MAP_B) || (idx == lgb_pkg::IDX_PIN_PULLDOWN) ||
		(idx == lgb_pkg::IDX_FWD_CFG) || (idx == lgb_pkg::IDX_BC_CFG) ||
		(idx == lgb_pkg::IDX_PIN_STATUS) ||
		((idx >= lgb_pkg::IDX_PIN_OUT_CFG0) && (idx < lgb_pkg::IDX_PIN_OUT_CFG0 + 8'(NP)));

	// Zero-wait slave; address bits above the map must be zero
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			efs_sync_reg <= 2'b00;
		end else begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
			efs_sync_reg <= {efs_sync_reg[0], ext_frame_sync};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_enable_reg <= lgb_pkg::RST_INPUT_ENABLE; // RULE_16
			pulldown_reg <= lgb_pkg::RST_PULLDOWN; // RULE_16
			bc_map_a_reg <= lgb_pkg::RST_BC_MAP;
			bc_map_b_reg <= lgb_pkg::RST_BC_MAP;
			fwd_cfg_reg <= lgb_pkg::RST_FWD_CFG;
			bc_cfg_reg <= lgb_pkg::RST_BC_CFG;
		end else if (wr_en && paddr[11:10] == 2'b00) begin
			case (idx)
				lgb_pkg::IDX_PIN_INPUT_ENABLE: input_enable_reg <= {1'b0, pwdata[NP-1:0]}; // RULE_17
				lgb_pkg::IDX_PIN_PULLDOWN: pulldown_reg <= {1'b0, pwdata[NP-1:0]}; // RULE_17
				lgb_pkg::IDX_BC_MAP_A: bc_map_a_reg <= pwdata[7:0];
				lgb_pkg::IDX_BC_MAP_B: bc_map_b_reg <= pwdata[7:0];
				lgb_pkg::IDX_FWD_CFG: fwd_cfg_reg <= pwdata[7:0];
				lgb_pkg::IDX_BC_CFG: bc_cfg_reg <= {7'h00, pwdata[0]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NP; i++) begin
				out_cfg_reg[i] <= lgb_pkg::RST_PIN_OUT_CFG; // RULE_09
			end
		end else if (wr_en && paddr[11:10] == 2'b00) begin
			for (int i = 0; i < NP; i++) begin
				if (idx == lgb_pkg::IDX_PIN_OUT_CFG0 + 8'(i)) begin
					out_cfg_reg[i] <= pwdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= psel && !penable && !(hit && paddr[11:10] == 2'b00);
			prdata_reg <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (idx)
					lgb_pkg::IDX_PIN_INPUT_ENABLE: prdata_reg <= {24'h0, input_enable_reg};
					lgb_pkg::IDX_PIN_PULLDOWN: prdata_reg <= {24'h0, pulldown_reg};
					lgb_pkg::IDX_BC_MAP_A: prdata_reg <= {24'h0, bc_map_a_reg};
					lgb_pkg::IDX_BC_MAP_B: prdata_reg <= {24'h0, bc_map_b_reg};
					lgb_pkg::IDX_FWD_CFG: prdata_reg <= {24'h0, fwd_cfg_reg};
					lgb_pkg::IDX_BC_CFG: prdata_reg <= {24'h0, bc_cfg_reg};
					lgb_pkg::IDX_PIN_STATUS: prdata_reg <= {17'h0, pin_oe_reg, 1'b0, pin_sync_reg & input_enable_reg[NP-1:0]};
					default: begin
						for (int i = 0; i < NP; i++) begin
							if (idx == lgb_pkg::IDX_PIN_OUT_CFG0 + 8'(i)) begin
								prdata_reg <= {24'h0, out_cfg_reg[i]};
							end
						end
					end
				endcase
			end
		end
	end

	lgb_fwd_rx u_fwd0 (
		.pclk(pclk),
		.presetn(presetn),
		.frame(fwd_frame0),
		.link_en(fwd_cfg_reg[3:0]),
		.video_mode(port_status.video_mode[0]),
		.values(fwd_val0)
	);

	lgb_fwd_rx u_fwd1 (
		.pclk(pclk),
		.presetn(presetn),
		.frame(fwd_frame1),
		.link_en(fwd_cfg_reg[7:4]),
		.video_mode(port_status.video_mode[1]),
		.values(fwd_val1)
	);

	// Disabled inputs read as zero so slots never see a floating pad
	always_comb begin
		for (int s = 0; s < lgb_pkg::BC_SLOTS; s++) begin
			slot_src0[s] = slot_pick(s[1] ? bc_map_b_reg[4*(s%2) +: 4] : bc_map_a_reg[4*(s%2) +: 4],
				pin_sync_reg & input_enable_reg[NP-1:0], frame_sync_signal, efs_sync_reg[1]);
		end
		// Port 1 reuses the same map; a per-port page would select its own copy
		slot_src1 = slot_src0;
	end

	lgb_bc_tx u_bc0 (
		.pclk(pclk),
		.presetn(presetn),
		.slow_rate(bc_cfg_reg[0]),
		.slot_src(slot_src0),
		.frame(bc_frame0)
	);

	lgb_bc_tx u_bc1 (
		.pclk(pclk),
		.presetn(presetn),
		.slow_rate(bc_cfg_reg[0]),
		.slot_src(slot_src1),
		.frame(bc_frame1)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out_reg <= '0;
			pin_oe_reg <= '0; // RULE_09
		end else begin
			for (int i = 0; i < NP; i++) begin
				pin_oe_reg[i] <= out_cfg_reg[i][lgb_pkg::POC_EN_BIT]; // RULE_01
				case (out_cfg_reg[i][lgb_pkg::POC_SRC_LSB +: 3])
					lgb_pkg::SRC_PORT0: pin_out_reg[i] <= out_cfg_reg[i][lgb_pkg::POC_SEL_LSB+2] ? 1'b0 :
						fwd_val0[out_cfg_reg[i][lgb_pkg::POC_SEL_LSB +: 2]]; // RULE_03
					lgb_pkg::SRC_PORT1: pin_out_reg[i] <= out_cfg_reg[i][lgb_pkg::POC_SEL_LSB+2] ? 1'b0 :
						fwd_val1[out_cfg_reg[i][lgb_pkg::POC_SEL_LSB +: 2]]; // RULE_03
					lgb_pkg::SRC_DEVICE: begin
						case (out_cfg_reg[i][lgb_pkg::POC_SEL_LSB +: 3])
							lgb_pkg::DEV_LEVEL: pin_out_reg[i] <= out_cfg_reg[i][lgb_pkg::POC_LEVEL_BIT]; // RULE_18
							lgb_pkg::DEV_OR_LOCK: pin_out_reg[i] <= |(port_status.lock & port_status.port_en); // RULE_18
							lgb_pkg::DEV_AND_LOCK: pin_out_reg[i] <= and_en(port_status.lock, port_status.port_en); // RULE_18
							lgb_pkg::DEV_AND_PASS: pin_out_reg[i] <= and_en(port_status.pass, port_status.port_en); // RULE_18
							lgb_pkg::DEV_FSYNC: pin_out_reg[i] <= frame_sync_signal; // RULE_08
							lgb_pkg::DEV_IRQ_HI: pin_out_reg[i] <= dev_irq; // RULE_08
							lgb_pkg::DEV_IRQ_LO: pin_out_reg[i] <= !dev_irq; // RULE_08
							default: pin_out_reg[i] <= 1'b0;
						endcase
					end
					default: pin_out_reg[i] <= 1'b0;
				endcase
			end
		end
	end

	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;
	assign pin_ie = input_enable_reg[NP-1:0]; // RULE_16
	assign pin_pd_en = ~pulldown_reg[NP-1:0]; // RULE_16
endmodule
`default_nettype wire

// file: lgb_properties.sv
// Purpose: Port-level checks of the link pin bridge
// Assumes: Single pclk domain, zero-wait APB slave
// Notes: Bound to lgb_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module lgb_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [lgb_pkg::NUM_PINS-1:0] pin_oe,
	input wire logic [lgb_pkg::NUM_PINS-1:0] pin_ie,
	input wire logic [lgb_pkg::NUM_PINS-1:0] pin_pd_en,
	input wire lgb_pkg::lgb_bc_frame_t bc_frame0,
	input wire lgb_pkg::lgb_bc_frame_t bc_frame1
);
	logic acc_wr;
	logic [6:0] wd_lo;
	assign acc_wr = psel && penable && pwrite;
	assign wd_lo = pwdata[6:0];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_zero_wait_a: assert property (psel && !penable |=> pready)
		else $error("access phase not ready at once");
	ie_write_a: assert property (acc_wr && paddr == 12'h03c |=> pin_ie == $past(wd_lo))
		else $error("input enable does not follow write");
	pd_write_a: assert property (acc_wr && paddr == 12'h2f8 |=> pin_pd_en == ~$past(wd_lo))
		else $error("pulldown enable does not follow write");
	unmapped_err_a: assert property (psel && penable && (paddr[11:10] != 2'b00 || paddr[9:2] == 8'h01) |-> pslverr)
		else $error("far address not refused");
	start_input_a: assert property ($rose(presetn) |-> pin_oe == 7'h00 && pin_ie == 7'h7f && pin_pd_en == 7'h7f)
		else $error("pins not inputs with pulldown after reset");
	oe_by_write_a: assert property ($changed(pin_oe) |-> $past(acc_wr, 2))
		else $error("output enable moved without a write");
	bc_gap_a: assert property (bc_frame0.strobe |=> !bc_frame0.strobe [*5])
		else $error("back-channel frames too close");
	bc_period_a: assert property (bc_frame0.strobe |-> ##[6:120] bc_frame0.strobe)
		else $error("back-channel frame missing");
	bc_hold_a: assert property (!bc_frame1.strobe |-> $stable(bc_frame1.bits))
		else $error("slot bits moved between frames");
	cover property (bc_frame0.strobe);
	cover property (acc_wr && paddr == 12'h03c);
	cover property (pslverr);
	cover property ($rose(pin_oe[0]));
endmodule
bind lgb_top lgb_properties lgb_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pslverr, .pin_oe, .pin_ie, .pin_pd_en, .bc_frame0, .bc_frame1);
`default_nettype wire

// file: lgb_ser_model.sv
// Purpose: Remote serializer model feeding forward frames to both ports
// Assumes: Frame strobe every gap cycles; gap of zero stops the link
// Notes: Both ports carry the same pattern
`timescale 1ns/1ps
`default_nettype none
module lgb_ser_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] gap,
	output lgb_pkg::lgb_fwd_frame_t fwd0,
	output lgb_pkg::lgb_fwd_frame_t fwd1
);
	logic [7:0] cnt_reg;
	logic phase_reg;
	logic last;
	assign last = (gap != 8'h00) && (cnt_reg == gap - 8'h01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
			phase_reg <= 1'b0;
		end else if (gap != 8'h00) begin
			cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
			if (last) phase_reg <= ~phase_reg;
		end
	end
	// Toggles every frame, above the advised rate, so a skipped update shows
	assign fwd0 = {{4{phase_reg}}, last};
	assign fwd1 = fwd0;
endmodule
`default_nettype wire

// file: link_gpio_bridge_bench.sv
// Purpose: Self-checking bench for the link pin bridge
// Assumes: Zero-wait APB slave, serializer model with 4-cycle frames
// Notes: Forward cadence judged by pin toggles over 20 frames
`timescale 1ns/1ps
`default_nettype none
module link_gpio_bridge_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fs_int, fs_ext, dev_irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0] pin_in, pin_out, pin_oe, pin_ie, pin_pd_en;
	lgb_pkg::lgb_fwd_frame_t fwd0, fwd1;
	lgb_pkg::lgb_port_status_t port_status;
	lgb_pkg::lgb_bc_frame_t bc0, bc1;
	int err_total = 0;
	int compares = 0;
	int cyc, ch;
	int fexp [4] = '{20, 0, 4, 4};
	logic [7:0] fcfg [4] = '{8'h01, 8'h03, 8'h07, 8'h0f};
	lgb_top lgb_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pin_in, .pin_out, .pin_oe, .pin_ie, .pin_pd_en, .fwd_frame0(fwd0), .fwd_frame1(fwd1), .port_status,
		.frame_sync_signal(fs_int), .ext_frame_sync(fs_ext), .dev_irq, .bc_frame0(bc0), .bc_frame1(bc1));
	lgb_ser_model lgb_ser_model_inst (.pclk, .presetn, .gap(8'h04), .fwd0, .fwd1);
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic is_wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
		@(posedge pclk);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
		apb(1'b0, idx, 32'h0);
		check(nm, exp, rd);
	endtask
	task automatic wait_bc(output int c);
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (bc0.strobe !== 1'b1 && c < 300);
		if (bc0.strobe !== 1'b1) begin
			err_total++;
			test_done();
		end
	endtask
	task automatic fwd_count(input logic [7:0] cfg, input int pin, output int n);
		logic prev;
		wr(lgb_pkg::IDX_FWD_CFG, {24'h0, cfg});
		repeat (60) @(posedge pclk);
		prev = pin_out[pin];
		n = 0;
		repeat (80) begin
			@(posedge pclk);
			if (pin_out[pin] !== prev) n++;
			prev = pin_out[pin];
		end
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, fs_int, fs_ext, dev_irq} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pin_in = 7'h00;
		port_status = 8'h7c;
		presetn = 1'b0;
		do_reset();
		check("pin_oe", 32'h0, pin_oe);
		check("pin_pd_en", 32'h7f, pin_pd_en);
		rchk(lgb_pkg::IDX_PIN_INPUT_ENABLE, 32'h7f, "input_enable");
		rchk(lgb_pkg::IDX_PIN_PULLDOWN, 32'h0, "pulldown");
		rchk(lgb_pkg::IDX_BC_MAP_A, 32'h0, "map_a");
		$display("test reset_values done");
		wr(lgb_pkg::IDX_PIN_INPUT_ENABLE, 32'h55);
		wr(lgb_pkg::IDX_PIN_PULLDOWN, 32'h0f);
		check("pin_ie", 32'h55, pin_ie);
		check("pin_pd_en", 32'h70, pin_pd_en);
		rchk(lgb_pkg::IDX_PIN_PULLDOWN, 32'h0f, "pulldown");
		wr(lgb_pkg::IDX_BC_MAP_B, 32'h5a);
		rchk(lgb_pkg::IDX_BC_MAP_B, 32'h5a, "map_b");
		apb(1'b0, 8'h01, 32'h0);
		check("unmapped_err", 32'h1, er);
		wr(lgb_pkg::IDX_PIN_INPUT_ENABLE, 32'h7f);
		$display("test registers done");
		for (int s = 0; s < 7; s++) begin
			wr(lgb_pkg::IDX_PIN_OUT_CFG0 + 8'(s), {24'h0, lgb_pkg::SRC_DEVICE, 3'(s), 2'b11});
		end
		{fs_int, fs_ext, dev_irq} <= 3'b111;
		repeat (4) @(posedge pclk);
		check("dev_pins_a", 32'h3b, pin_out);
		check("pin_oe", 32'h7f, pin_oe);
		port_status <= 8'hdc;
		{fs_int, fs_ext, dev_irq} <= 3'b000;
		repeat (4) @(posedge pclk);
		check("dev_pins_b", 32'h47, pin_out);
		$display("test device_select done");
		wr(lgb_pkg::IDX_PIN_OUT_CFG0, 32'h01);
		wr(lgb_pkg::IDX_PIN_OUT_CFG0 + 8'h01, 32'h29);
		for (int i = 0; i < 4; i++) begin
			fwd_count(fcfg[i], 0, ch);
			check("fwd_toggles", fexp[i], ch);
		end
		fwd_count(8'h40, 1, ch);
		check("port1_toggles", 32'd20, ch);
		port_status <= 8'hdd;
		fwd_count(8'h01, 0, ch);
		check("video_toggles", 32'd0, ch);
		$display("test forward done");
		wr(lgb_pkg::IDX_BC_MAP_A, 32'h33);
		wr(lgb_pkg::IDX_BC_MAP_B, 32'hf7);
		// Held for about three frames, below the sampling rate
		pin_in <= 7'h08;
		fs_int <= 1'b1;
		repeat (3) wait_bc(cyc);
		check("bc0_bits", 32'h7, bc0.bits);
		check("bc1_bits", 32'h7, bc1.bits);
		check("bc_fast", 32'd6, cyc);
		rchk(lgb_pkg::IDX_PIN_STATUS, 32'h7f08, "status");
		pin_in <= 7'h00;
		{fs_int, fs_ext} <= 2'b01;
		repeat (3) wait_bc(cyc);
		check("bc0_bits", 32'h8, bc0.bits);
		wr(lgb_pkg::IDX_BC_CFG, 32'h1);
		repeat (2) wait_bc(cyc);
		check("bc_slow", 32'd120, cyc);
		$display("test back_channel done");
		do_reset();
		check("pin_oe", 32'h0, pin_oe);
		check("pin_ie", 32'h7f, pin_ie);
		$display("test second_reset done");
		test_done();
	end
endmodule
`default_nettype wire
